// File: sidetone_loop_eq_pkg.sv
/*
  Constants, register map and carrier types for the sidetone mixer,
  echo-reference loop and five band equaliser control block.
  Assumes a classic Wishbone slave with 32-bit data, one register per
  aligned word at byte address four times the register index.
*/
// How it works
// [RULE_01] sidetone gain: -36 dB, 3 dB steps, 11XX 0 dB
// [RULE_02] right DAC source: 01 left, 10 right ADC
// [RULE_03] left DAC source: same coding, 00/11 off
// [RULE_04] sidetone taken after ADC high-pass filter
// [RULE_05] sidetone added to receive data before DAC
// [RULE_06] loop enable replaces transmit data with loop
// [RULE_07] select 0: left ADC, then DAC average
// [RULE_08] select 1: DAC average, then right ADC
// [RULE_09] DAC average uses post-volume DAC samples
// [RULE_10] equaliser bit 0 enables, resets to bypass
// [RULE_11] five independent band gains to filter engine
// [RULE_12] default band frequencies fixed, scale with rate
// [RULE_13] band gain 5 bits, 01100 0 dB, reserved clamp
// [RULE_14] band 1 at 15:11, band 2 at 10:6
// [RULE_15] bit 2 set: both channels share coefficients
// [RULE_16] bit 1 picks shared set: 0 left, 1 right
// [RULE_17] user coefficients at 338-355 and 358-375
// [RULE_18] loop off: transmit carries normal ADC data
package sidetone_loop_eq_pkg;

  localparam int SAMPLE_W = 24;
  localparam int COEF_WORDS = 18;

  // register indices (byte address is index * 4)
  localparam logic [9:0] IDX_RIGHT_SIDETONE = 10'h039;
  localparam logic [9:0] IDX_LEFT_SIDETONE = 10'h03a;
  localparam logic [9:0] IDX_ECHO_LOOP = 10'h11d;
  localparam logic [9:0] IDX_EQ_CONTROL = 10'h14f;
  localparam logic [9:0] IDX_LEFT_GAIN_A = 10'h150;
  localparam logic [9:0] IDX_LEFT_GAIN_B = 10'h151;
  localparam logic [9:0] IDX_LEFT_COEF_FIRST = 10'h152;
  localparam logic [9:0] IDX_LEFT_COEF_LAST = 10'h163;
  localparam logic [9:0] IDX_RIGHT_GAIN_A = 10'h164;
  localparam logic [9:0] IDX_RIGHT_GAIN_B = 10'h165;
  localparam logic [9:0] IDX_RIGHT_COEF_FIRST = 10'h166;
  localparam logic [9:0] IDX_RIGHT_COEF_LAST = 10'h177;

  // field positions
  localparam int SIDETONE_GAIN_LSB = 4;
  localparam int SIDETONE_SRC_LSB = 2;
  localparam int LOOP_ENABLE_BIT = 1;
  localparam int LOOP_SELECT_BIT = 0;
  localparam int EQ_ON_BIT = 0;
  localparam int EQ_SIDE_BIT = 1;
  localparam int EQ_COMMON_BIT = 2;
  localparam int BAND_HI_LSB = 11;
  localparam int BAND_MID_LSB = 6;
  localparam int BAND_LO_LSB = 1;

  // reset values
  localparam logic [15:0] RST_SIDETONE = 16'h0000;
  localparam logic [15:0] RST_ECHO_LOOP = 16'h0000;
  localparam logic [15:0] RST_EQ_CONTROL = 16'h0004;
  localparam logic [15:0] RST_GAIN_A = 16'h6318;
  localparam logic [15:0] RST_GAIN_B = 16'h6300;
  localparam logic [15:0] RST_COEF = 16'h0000;

  // sidetone source codes
  localparam logic [1:0] SRC_LEFT_ADC = 2'h1;
  localparam logic [1:0] SRC_RIGHT_ADC = 2'h2;

  // band gain codes
  localparam logic [4:0] BAND_GAIN_MAX = 5'h18;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
  } stereo_s;

  typedef struct packed {
    logic [4:0] b1;
    logic [4:0] b2;
    logic [4:0] b3;
    logic [4:0] b4;
    logic [4:0] b5;
  } band_gains_s;

endpackage

// File: sidetone_loop_eq_ctrl.sv
/*
  Sidetone mixer, echo-reference loop and five band equaliser control,
  with a classic Wishbone register slave.
  Assumes all sample inputs are synchronous to core_clk and qualified by
  a one-cycle sample_valid pulse; the filter engine reads coefficients
  through the registered lookup port.
*/
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sidetone_loop_eq_ctrl (
  input wire logic core_clk, // 10 MHz core clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [11:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic sample_valid, // one-cycle new sample strobe
  input wire sidetone_loop_eq_pkg::stereo_s adc_hpf, // ADC after HPF
  input wire sidetone_loop_eq_pkg::stereo_s adc_routed, // normal tx data
  input wire sidetone_loop_eq_pkg::stereo_s port_rx, // serial port rx
  input wire sidetone_loop_eq_pkg::stereo_s dac_post_vol, // DAC after vol
  input wire logic coef_rd_chan, // lookup channel, 1 right
  input wire logic [4:0] coef_rd_idx, // lookup coefficient index
  output sidetone_loop_eq_pkg::stereo_s dac_in, // DAC input samples
  output sidetone_loop_eq_pkg::stereo_s port_tx, // serial port tx
  output logic dac_out_valid, // dac_in and port_tx updated
  output logic five_band_equaliser_on, // equaliser processes samples
  output sidetone_loop_eq_pkg::band_gains_s eq_left_gains, // left gains
  output sidetone_loop_eq_pkg::band_gains_s eq_right_gains, // right
  output logic [15:0] coef_rd_data // coefficient lookup result
);

  localparam int SW = sidetone_loop_eq_pkg::SAMPLE_W;
  localparam int CW = sidetone_loop_eq_pkg::COEF_WORDS;

  logic [15:0] right_sidetone_control;
  logic [15:0] left_sidetone_control;
  logic [15:0] echo_loop_control;
  logic [15:0] equaliser_control;
  logic [15:0] left_band_gain_a;
  logic [15:0] left_band_gain_b;
  logic [15:0] right_band_gain_a;
  logic [15:0] right_band_gain_b;
  logic [15:0] coef_mem [0:2*CW-1];

  logic [9:0] idx;
  logic bus_req;
  logic wr_stb;
  logic [15:0] wr_mask;
  logic [15:0] wr_data;
  logic coef_hit;
  logic [5:0] coef_addr;
  logic [15:0] next_rd;

  // ---------------------------------------------------------------
  // bus slave: ack one cycle after the request, dropped the next
  // ---------------------------------------------------------------
  assign idx = wb_adr_i[11:2];
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = bus_req & wb_we_i;
  assign wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wr_data = wb_dat_i[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old_v);
    merge = (old_v & ~wr_mask) | (wr_data & wr_mask);
  endfunction

  always_comb begin
    coef_hit = 1'b0;
    coef_addr = 6'h00;
    if (idx >= sidetone_loop_eq_pkg::IDX_LEFT_COEF_FIRST &&
        idx <= sidetone_loop_eq_pkg::IDX_LEFT_COEF_LAST) begin
      coef_hit = 1'b1; // RULE_17
      coef_addr = 6'(idx - sidetone_loop_eq_pkg::IDX_LEFT_COEF_FIRST);
    end else if (idx >= sidetone_loop_eq_pkg::IDX_RIGHT_COEF_FIRST &&
                 idx <= sidetone_loop_eq_pkg::IDX_RIGHT_COEF_LAST) begin
      coef_hit = 1'b1; // RULE_17
      coef_addr = 6'(idx - sidetone_loop_eq_pkg::IDX_RIGHT_COEF_FIRST
                  + 10'(CW));
    end
  end

  always_comb begin
    next_rd = 16'h0000;
    if (idx == sidetone_loop_eq_pkg::IDX_RIGHT_SIDETONE) begin
      next_rd = right_sidetone_control;
    end else if (idx == sidetone_loop_eq_pkg::IDX_LEFT_SIDETONE) begin
      next_rd = left_sidetone_control;
    end else if (idx == sidetone_loop_eq_pkg::IDX_ECHO_LOOP) begin
      next_rd = echo_loop_control;
    end else if (idx == sidetone_loop_eq_pkg::IDX_EQ_CONTROL) begin
      next_rd = equaliser_control;
    end else if (idx == sidetone_loop_eq_pkg::IDX_LEFT_GAIN_A) begin
      next_rd = left_band_gain_a;
    end else if (idx == sidetone_loop_eq_pkg::IDX_LEFT_GAIN_B) begin
      next_rd = left_band_gain_b;
    end else if (idx == sidetone_loop_eq_pkg::IDX_RIGHT_GAIN_A) begin
      next_rd = right_band_gain_a;
    end else if (idx == sidetone_loop_eq_pkg::IDX_RIGHT_GAIN_B) begin
      next_rd = right_band_gain_b;
    end else if (coef_hit) begin
      next_rd = coef_mem[coef_addr];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= {16'h0000, next_rd};
      end
    end
  end

  // control registers; only the documented fields are stored
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      right_sidetone_control <= sidetone_loop_eq_pkg::RST_SIDETONE;
      left_sidetone_control <= sidetone_loop_eq_pkg::RST_SIDETONE;
      echo_loop_control <= sidetone_loop_eq_pkg::RST_ECHO_LOOP;
      equaliser_control <= sidetone_loop_eq_pkg::RST_EQ_CONTROL; // RULE_10
      left_band_gain_a <= sidetone_loop_eq_pkg::RST_GAIN_A; // RULE_13
      left_band_gain_b <= sidetone_loop_eq_pkg::RST_GAIN_B;
      right_band_gain_a <= sidetone_loop_eq_pkg::RST_GAIN_A;
      right_band_gain_b <= sidetone_loop_eq_pkg::RST_GAIN_B;
    end else if (wr_stb) begin
      if (idx == sidetone_loop_eq_pkg::IDX_RIGHT_SIDETONE) begin
        right_sidetone_control <= merge(right_sidetone_control) &
                                  16'h00fc;
      end else if (idx == sidetone_loop_eq_pkg::IDX_LEFT_SIDETONE) begin
        left_sidetone_control <= merge(left_sidetone_control) & 16'h00fc;
      end else if (idx == sidetone_loop_eq_pkg::IDX_ECHO_LOOP) begin
        echo_loop_control <= merge(echo_loop_control) & 16'h0003;
      end else if (idx == sidetone_loop_eq_pkg::IDX_EQ_CONTROL) begin
        equaliser_control <= merge(equaliser_control) & 16'h0007;
      end else if (idx == sidetone_loop_eq_pkg::IDX_LEFT_GAIN_A) begin
        left_band_gain_a <= merge(left_band_gain_a) & 16'hfffe; // RULE_14
      end else if (idx == sidetone_loop_eq_pkg::IDX_LEFT_GAIN_B) begin
        left_band_gain_b <= merge(left_band_gain_b) & 16'hffc0;
      end else if (idx == sidetone_loop_eq_pkg::IDX_RIGHT_GAIN_A) begin
        right_band_gain_a <= merge(right_band_gain_a) & 16'hfffe;
      end else if (idx == sidetone_loop_eq_pkg::IDX_RIGHT_GAIN_B) begin
        right_band_gain_b <= merge(right_band_gain_b) & 16'hffc0;
      end
    end
  end

  // user coefficient store, one bank per channel
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 2 * CW; i++) begin
        coef_mem[i] <= sidetone_loop_eq_pkg::RST_COEF;
      end
    end else if (wr_stb && coef_hit) begin
      coef_mem[coef_addr] <= merge(coef_mem[coef_addr]); // RULE_17
    end
  end

  // ---------------------------------------------------------------
  // equaliser control towards the filter engine
  // ---------------------------------------------------------------
  logic common_coefficient_on;
  logic common_coefficient_side;
  logic coef_bank;
  logic [5:0] coef_rd_addr;

  assign common_coefficient_on =
    equaliser_control[sidetone_loop_eq_pkg::EQ_COMMON_BIT];
  assign common_coefficient_side =
    equaliser_control[sidetone_loop_eq_pkg::EQ_SIDE_BIT];
  // shared mode overrides the requesting channel's own bank
  assign coef_bank = common_coefficient_on ? common_coefficient_side
                                           : coef_rd_chan; // RULE_15 RULE_16
  assign coef_rd_addr = coef_bank ? 6'(coef_rd_idx + 5'(CW))
                                  : {1'b0, coef_rd_idx};

  // reserved codes above +12 dB are applied as +12 dB
  function automatic logic [4:0] band(input logic [15:0] r, input int lsb);
    logic [4:0] g;
    g = r[lsb +: 5];
    band = (g > sidetone_loop_eq_pkg::BAND_GAIN_MAX) ?
           sidetone_loop_eq_pkg::BAND_GAIN_MAX : g; // RULE_13
  endfunction

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      five_band_equaliser_on <= 1'b0;
      eq_left_gains <= '0;
      eq_right_gains <= '0;
      coef_rd_data <= 16'h0000;
    end else begin
      five_band_equaliser_on <=
        equaliser_control[sidetone_loop_eq_pkg::EQ_ON_BIT]; // RULE_10
      // each band and channel carries its own gain; band frequencies
      // stay fixed unless the engine loads user coefficients
      eq_left_gains <= '{ // RULE_11 RULE_12 RULE_14
        band(left_band_gain_a, sidetone_loop_eq_pkg::BAND_HI_LSB),
        band(left_band_gain_a, sidetone_loop_eq_pkg::BAND_MID_LSB),
        band(left_band_gain_a, sidetone_loop_eq_pkg::BAND_LO_LSB),
        band(left_band_gain_b, sidetone_loop_eq_pkg::BAND_HI_LSB),
        band(left_band_gain_b, sidetone_loop_eq_pkg::BAND_MID_LSB)};
      eq_right_gains <= '{ // RULE_11
        band(right_band_gain_a, sidetone_loop_eq_pkg::BAND_HI_LSB),
        band(right_band_gain_a, sidetone_loop_eq_pkg::BAND_MID_LSB),
        band(right_band_gain_a, sidetone_loop_eq_pkg::BAND_LO_LSB),
        band(right_band_gain_b, sidetone_loop_eq_pkg::BAND_HI_LSB),
        band(right_band_gain_b, sidetone_loop_eq_pkg::BAND_MID_LSB)};
      coef_rd_data <= coef_mem[coef_rd_addr];
    end
  end

  // ---------------------------------------------------------------
  // sidetone mixer
  // ---------------------------------------------------------------
  // attenuation as an unsigned fraction of 2^15
  function automatic logic [15:0] st_gain(input logic [3:0] code);
    case (code)
      4'h0: st_gain = 16'h0207;
      4'h1: st_gain = 16'h02dd;
      4'h2: st_gain = 16'h040c;
      4'h3: st_gain = 16'h05b8;
      4'h4: st_gain = 16'h0814;
      4'h5: st_gain = 16'h0b68;
      4'h6: st_gain = 16'h101d;
      4'h7: st_gain = 16'h16c3;
      4'h8: st_gain = 16'h2027;
      4'h9: st_gain = 16'h2d6b;
      4'ha: st_gain = 16'h4027;
      4'hb: st_gain = 16'h5a9e;
      default: st_gain = 16'h8000;
    endcase
  endfunction

  // sidetone source picks from the post-HPF ADC samples only
  function automatic logic signed [SW-1:0] st_pick(input logic [1:0] s);
    case (s)
      sidetone_loop_eq_pkg::SRC_LEFT_ADC: st_pick = adc_hpf.left;
      sidetone_loop_eq_pkg::SRC_RIGHT_ADC: st_pick = adc_hpf.right;
      default: st_pick = '0;
    endcase
  endfunction

  function automatic logic signed [SW-1:0] st_mix(
    input logic signed [SW-1:0] rx, input logic [15:0] ctl);
    logic signed [SW-1:0] src;
    logic signed [SW+16:0] prod;
    logic signed [SW:0] sum;
    src = st_pick(ctl[sidetone_loop_eq_pkg::SIDETONE_SRC_LSB +: 2]);
    prod = src * $signed({1'b0,
           st_gain(ctl[sidetone_loop_eq_pkg::SIDETONE_GAIN_LSB +: 4])});
    sum = rx + $signed(prod[SW+14:15]);
    // saturate rather than wrap at full scale
    if (sum[SW] != sum[SW-1]) begin
      st_mix = sum[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
    end else begin
      st_mix = sum[SW-1:0];
    end
  endfunction

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_in <= '0;
    end else if (sample_valid) begin
      dac_in.left <= st_mix(port_rx.left,
                            left_sidetone_control); // RULE_01 RULE_03 RULE_04 RULE_05
      dac_in.right <= st_mix(port_rx.right,
                             right_sidetone_control); // RULE_01 RULE_02 RULE_04 RULE_05
    end
  end

  // ---------------------------------------------------------------
  // echo-reference loop on the transmit slots
  // ---------------------------------------------------------------
  logic echo_loop_enable;
  logic echo_loop_select;
  logic signed [SW:0] dac_sum;
  logic signed [SW-1:0] dac_avg;

  assign echo_loop_enable =
    echo_loop_control[sidetone_loop_eq_pkg::LOOP_ENABLE_BIT];
  assign echo_loop_select =
    echo_loop_control[sidetone_loop_eq_pkg::LOOP_SELECT_BIT];
  // post-volume samples, so a muted channel adds zero and halves the average
  assign dac_sum = dac_post_vol.left + dac_post_vol.right; // RULE_09
  assign dac_avg = dac_sum[SW:1];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_tx <= '0;
    end else if (sample_valid) begin
      if (!echo_loop_enable) begin
        port_tx <= adc_routed; // RULE_18
      end else if (!echo_loop_select) begin
        port_tx <= '{adc_hpf.left, dac_avg}; // RULE_06 RULE_07
      end else begin
        port_tx <= '{dac_avg, adc_hpf.right}; // RULE_06 RULE_08
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_out_valid <= 1'b0;
    end else begin
      dac_out_valid <= sample_valid;
    end
  end

endmodule // sidetone_loop_eq_ctrl
`default_nettype wire

// File: sle_checker_assertions.sv
/* Port checks for the sidetone, echo loop and equaliser block.
   Assumes Wishbone writes take effect at the edge that takes them. */
`timescale 1ns/10ps
`default_nettype none
module sle_checker (
  input wire logic core_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [11:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic sample_valid, // sample strobe
  input wire sidetone_loop_eq_pkg::stereo_s adc_hpf, // filtered adc
  input wire sidetone_loop_eq_pkg::stereo_s adc_routed, // normal tx
  input wire sidetone_loop_eq_pkg::stereo_s dac_post_vol, // dac
  input wire sidetone_loop_eq_pkg::stereo_s port_tx, // tx slots
  input wire logic dac_out_valid, // result strobe
  input wire logic five_band_equaliser_on, // equaliser on
  input wire sidetone_loop_eq_pkg::band_gains_s eq_left_gains // gains
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [1:0] loop_q;
  logic eq_q;
  logic wr_w;
  logic [24:0] sum;
  logic [23:0] avg;
  // register shadows follow accepted low-byte writes
  assign wr_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign sum = {dac_post_vol.left[23], dac_post_vol.left}
    + {dac_post_vol.right[23], dac_post_vol.right};
  assign avg = sum[24:1];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      loop_q <= 2'h0;
    end else if (wr_w && wb_adr_i[11:2] == 10'h11d) begin
      loop_q <= wb_dat_i[1:0];
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eq_q <= 1'b0;
    end else if (wr_w && wb_adr_i[11:2] == 10'h14f) begin
      eq_q <= wb_dat_i[0];
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_smp(logic [1:0] m);
    sample_valid && loop_q == m;
  endsequence
  chk_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_valid_lag: assert property (dac_out_valid == $past(sample_valid))
    else $error("result strobe misplaced");
  chk_loop_off: assert property (
    sample_valid && !loop_q[1] |=> port_tx == $past(adc_routed))
    else $error("tx not routed adc");
  chk_loop_sel0: assert property (s_smp(2'h2) |=>
    port_tx.left == $past(adc_hpf.left) && port_tx.right == $past(avg))
    else $error("loop select 0 wrong");
  chk_loop_sel1: assert property (s_smp(2'h3) |=>
    port_tx.left == $past(avg) && port_tx.right == $past(adc_hpf.right))
    else $error("loop select 1 wrong");
  chk_eq_follow: assert property (
    $changed(eq_q) |-> ##[0:1] five_band_equaliser_on == eq_q)
    else $error("equaliser enable lag");
  chk_gain_clamp: assert property (eq_left_gains.b1 <= 5'h18 &&
    eq_left_gains.b2 <= 5'h18 && eq_left_gains.b3 <= 5'h18)
    else $error("gain above top code");
endmodule // sle_checker
bind sidetone_loop_eq_ctrl sle_checker sle_checker_i (
  .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sample_valid(sample_valid), .adc_hpf(adc_hpf),
  .adc_routed(adc_routed), .dac_post_vol(dac_post_vol),
  .port_tx(port_tx), .dac_out_valid(dac_out_valid),
  .five_band_equaliser_on(five_band_equaliser_on),
  .eq_left_gains(eq_left_gains));
`default_nettype wire

// File: audio_proc_model.sv
/* External audio processor on the serial audio port.
   Sends receive words on request and keeps the last transmit word seen. */
`timescale 1ns/10ps
`default_nettype none
module audio_proc_model (
  input wire logic core_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic dac_out_valid, // new transmit word
  input wire sidetone_loop_eq_pkg::stereo_s port_tx, // transmit slots
  output sidetone_loop_eq_pkg::stereo_s port_rx, // receive slots
  output sidetone_loop_eq_pkg::stereo_s tx_seen // last transmit word
);
  initial port_rx = '0;
  task automatic send(input sidetone_loop_eq_pkg::stereo_s v);
    port_rx <= v;
  endtask
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_seen <= '0;
    end else if (dac_out_valid) begin
      tx_seen <= port_tx;
    end
  end
endmodule // audio_proc_model
`default_nettype wire

// File: sidetone_loop_eq_ctrl_test.sv
/* Self-checking bench: registers over classic Wishbone, samples through
   the audio processor model, expectations from the register rules. */
`timescale 1ns/10ps
`default_nettype none
module sidetone_loop_eq_ctrl_test;
  logic core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic sample_valid, dac_out_valid, five_band_equaliser_on, coef_rd_chan;
  logic [4:0] coef_rd_idx;
  logic [15:0] coef_rd_data;
  sidetone_loop_eq_pkg::stereo_s adc_hpf, adc_routed, port_rx,
    dac_post_vol, dac_in, port_tx, tx_seen;
  sidetone_loop_eq_pkg::band_gains_s eq_left_gains, eq_right_gains;
  int fails = 0;
  int total_checks = 0;
  int cyc_n = 0;
  logic [15:0] gtab [16];
  sidetone_loop_eq_ctrl sidetone_loop_eq_ctrl_i (.*);
  audio_proc_model audio_proc_model_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [47:0] e, logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic wb(logic w, logic [9:0] i, logic [15:0] d, logic [3:0] s,
                    output logic [31:0] q);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {16'h0000, d};
    @(posedge core_clk);
    n = 0;
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20) begin
      $display("Error wb ack expected 1 seen %b", wb_ack_o);
      fails++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(logic [9:0] i, logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, i, d, 4'hf, q);
  endtask
  task automatic rd(logic [9:0] i, logic [15:0] e);
    logic [31:0] q;
    wb(1'b0, i, 16'h0000, 4'hf, q);
    chk($sformatf("reg %h", i), {16'h0000, 16'h0000, e}, {16'h0000, q});
  endtask
  task automatic settle();
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic smp(sidetone_loop_eq_pkg::stereo_s a, r, x, v);
    @(posedge core_clk);
    adc_hpf <= a;
    adc_routed <= r;
    dac_post_vol <= v;
    audio_proc_model_i.send(x);
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    settle();
  endtask
  function automatic logic [23:0] st(logic [23:0] s, logic [3:0] c);
    logic signed [40:0] p;
    p = $signed(s) * $signed({1'b0, gtab[c]});
    return p[38:15];
  endfunction
  function automatic logic [23:0] pick(logic [1:0] s);
    return s == 2'h1 ? 24'h100000 : s == 2'h2 ? 24'hf00000 : 24'h000000;
  endfunction
  task automatic t_regs();
    logic [31:0] q;
    rd(10'h14f, 16'h0004);
    rd(10'h150, 16'h6318);
    rd(10'h151, 16'h6300);
    rd(10'h11d, 16'h0000);
    rd(10'h3ff, 16'h0000);
    chk("eq on", 48'h0, five_band_equaliser_on);
    chk("right rst", {5{5'h0c}}, eq_right_gains);
    wr(10'h165, 16'h0840);
    settle();
    chk("right b4 b5", {5'h0c, 5'h0c, 5'h0c, 5'h01, 5'h01},
        eq_right_gains);
    wr(10'h150, 16'hf9c0);
    settle();
    chk("b1", 48'h18, eq_left_gains.b1);
    chk("b2", 48'h07, eq_left_gains.b2);
    rd(10'h150, 16'hf9c0);
    wb(1'b1, 10'h150, 16'h0000, 4'h1, q);
    rd(10'h150, 16'hf900);
    wr(10'h14f, 16'hfff9);
    rd(10'h14f, 16'h0001);
    settle();
    chk("eq on", 48'h1, five_band_equaliser_on);
    $display("t_regs done");
  endtask
  task automatic t_side();
    for (int c = 0; c < 16; c++) begin
      wr(10'h03a, {8'h00, c[3:0], 4'h4});
      wr(10'h039, {8'h00, c[3:0], 4'h8});
      smp({24'h100000, 24'hf00000}, {24'h050000, 24'h060000},
          {24'h000100, 24'h000200}, '0);
      chk("dac gain", {24'h000100 + st(24'h100000, c[3:0]),
          24'h000200 + st(24'hf00000, c[3:0])}, dac_in);
    end
    for (int s = 0; s < 4; s++) begin
      wr(10'h03a, {8'h00, 4'hc, s[1:0], 2'h0});
      wr(10'h039, {8'h00, 4'hc, 2'h3 - s[1:0], 2'h0});
      smp({24'h100000, 24'hf00000}, '0, {24'h000100, 24'h000200}, '0);
      chk("dac src", {24'h000100 + pick(s[1:0]),
          24'h000200 + pick(2'h3 - s[1:0])}, dac_in);
    end
    $display("t_side done");
  endtask
  task automatic t_loop();
    logic [47:0] a;
    logic [47:0] r;
    a = {24'h111111, 24'h222222};
    r = {24'h333333, 24'h444444};
    wr(10'h11d, 16'h0001);
    smp(a, r, '0, {24'h100000, 24'h300000});
    chk("tx off", r, tx_seen);
    wr(10'h11d, 16'h0002);
    smp(a, r, '0, {24'h100000, 24'h300000});
    chk("tx sel0", {24'h111111, 24'h200000}, tx_seen);
    wr(10'h11d, 16'h0003);
    smp(a, r, '0, {24'hfffffe, 24'hfffffb});
    chk("tx sel1", {24'hfffffc, 24'h222222}, tx_seen);
    smp(a, r, '0, {24'h100000, 24'h000000});
    chk("tx one dac", {24'h080000, 24'h222222}, tx_seen);
    wr(10'h11d, 16'h0000);
    $display("t_loop done");
  endtask
  task automatic cf(logic [15:0] ctl, logic ch, logic [15:0] e);
    wr(10'h14f, ctl);
    @(posedge core_clk);
    coef_rd_chan <= ch;
    coef_rd_idx <= 5'h03;
    settle();
    settle();
    chk("coef", {32'h0000_0000, e}, {32'h0000_0000, coef_rd_data});
  endtask
  task automatic t_coef();
    wr(10'h155, 16'h1234);
    wr(10'h169, 16'habcd);
    cf(16'h0004, 1'b1, 16'h1234);
    cf(16'h0006, 1'b0, 16'habcd);
    cf(16'h0000, 1'b0, 16'h1234);
    cf(16'h0000, 1'b1, 16'habcd);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(10'h14f, 16'h0004);
    rd(10'h169, 16'h0000);
    $display("t_coef done");
  endtask
  initial begin
    gtab = '{16'h0207, 16'h02dd, 16'h040c, 16'h05b8, 16'h0814, 16'h0b68,
             16'h101d, 16'h16c3, 16'h2027, 16'h2d6b, 16'h4027, 16'h5a9e,
             16'h8000, 16'h8000, 16'h8000, 16'h8000};
    arst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, sample_valid, coef_rd_chan} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, coef_rd_idx} = '0;
    {adc_hpf, adc_routed, dac_post_vol} = '0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_side();
    t_loop();
    t_coef();
    tally_and_finish();
  end
endmodule // sidetone_loop_eq_ctrl_test
`default_nettype wire
